// ==== rtl/pbsc_ctrl.v ====
// Function
// - from soft-off or sleep, a press under six seconds powers the system on
// - a short press while working enters the sleep state the OS selected
// - holding over six seconds forces soft-off from working or sleep
// - software soft-off request powers down without the switch
// - suspend-to-RAM keeps memory powered, processor off, wake logic on
// - suspend-to-disk powers off processor and devices, wake logic on
// - soft-off keeps only wake logic; leaving it for working signals a cold boot
// - mechanical-off powers nothing; wake logic only on battery
// - several independent wake sources return sleep to working
// - the PCIe wake signal wakes from S3, S4 or S5
// - after AC loss restore the previous on/off state, if configured
`timescale 1ns/1ps
`include "pbsc_regs.vh"

module pbsc_ctrl #(
    parameter [`PBSC_CNT_W-1:0] SHORT_CYC = `PBSC_SHORT_CYC,
    parameter [`PBSC_CNT_W-1:0] LONG_CYC  = `PBSC_LONG_CYC
) (
    // clock and reset
    input  wire                   clk_sys,
    input  wire                   rst,
    // supply and switch
    input  wire                   ac_present,
    input  wire                   pwr_switch,
    // operating system requests
    input  wire [1:0]             os_sleep_sel,
    input  wire                   os_sleep_req,
    input  wire                   os_off_req,
    // configuration
    input  wire                   restore_last,
    // wake sources: the pcie wake line (active low) and the others
    input  wire                   pcie_wake_n,
    input  wire [`PBSC_WAKE_N-2:0] wake_evt,
    // power rails and status
    output reg  [`PBSC_ST_W-1:0]  sys_state,
    output reg                    cpu_pwr_en,
    output reg                    mem_pwr_en,
    output reg                    dev_pwr_en,
    output reg                    wake_pwr_en,
    output reg                    cold_boot,
    output reg                    force_off_evt
);

// ----------------------------------------
// state codes
// ----------------------------------------
// kept equal to the sleeping state numbers so status reads naturally
localparam [`PBSC_ST_W-1:0] ST_S0 = `PBSC_ST_S0;
localparam [`PBSC_ST_W-1:0] ST_S3 = `PBSC_ST_S3;
localparam [`PBSC_ST_W-1:0] ST_S4 = `PBSC_ST_S4;
localparam [`PBSC_ST_W-1:0] ST_S5 = `PBSC_ST_S5;
localparam [`PBSC_ST_W-1:0] ST_G3 = `PBSC_ST_G3;

// ----------------------------------------
// state and press timer
// ----------------------------------------
// short threshold stays a parameter; every press under the long bound acts on release
reg  [`PBSC_ST_W-1:0]  state_reg;
reg  [`PBSC_ST_W-1:0]  state_next;
reg  [`PBSC_CNT_W-1:0] press_cnt_reg;
reg  [`PBSC_CNT_W-1:0] press_cnt_next;
reg                    sw_dly_reg;
reg                    forced_reg;     // long press already acted
reg                    forced_next;
reg                    last_on_reg;    // on/off before ac loss
reg                    last_on_next;

wire [`PBSC_CNT_W-1:0] cnt_inc   = press_cnt_reg + 32'h1;
wire                   cnt_full  = (press_cnt_reg == 32'hffffffff);
wire                   sw_rel    = sw_dly_reg & ~pwr_switch;
wire                   long_hit  = pwr_switch & ~forced_reg & (press_cnt_reg >= LONG_CYC);
// short and mid presses act alike on release, so only the 6 s bound
// separates them from the long press, which fires while still held
wire                   short_rel = sw_rel & ~forced_reg;
wire                   wake_any  = ~pcie_wake_n | (|wake_evt);
// wake inputs only count in a sleep state; working and g3 ignore them
wire                   is_sleep  = (state_reg == ST_S3) | (state_reg == ST_S4) |
                                   (state_reg == ST_S5);
wire                   wake_hit  = is_sleep & wake_any;
wire                   can_force = (state_reg == ST_S0) | (state_reg == ST_S3) |
                                   (state_reg == ST_S4);

// ----------------------------------------
// next state
// ----------------------------------------
// ac loss is checked last so it overrides every other cause
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_G3: begin
            if (ac_present) begin
                if (restore_last & last_on_reg) begin
                    state_next = ST_S0;
                end else begin
                    state_next = ST_S5;
                end
            end
        end
        ST_S0: begin
            if (long_hit) begin
                state_next = ST_S5;
            end else if (os_off_req) begin
                state_next = ST_S5;
            end else if (os_sleep_req | short_rel) begin
                case (os_sleep_sel)
                    `PBSC_SEL_S3: state_next = ST_S3;
                    `PBSC_SEL_S4: state_next = ST_S4;
                    default:      state_next = ST_S5;
                endcase
            end
        end
        ST_S3, ST_S4: begin
            if (long_hit) begin
                state_next = ST_S5;
            end else if (short_rel | wake_hit) begin
                state_next = ST_S0;
            end
        end
        ST_S5: begin
            if (short_rel | wake_hit) begin
                state_next = ST_S0;
            end
        end
        default: begin
            state_next = ST_G3;
        end
    endcase
    if (~ac_present) begin
        state_next = ST_G3;
    end
end

// ----------------------------------------
// press timer
// ----------------------------------------
// saturate so a stuck switch cannot wrap into a fresh press
always @* begin
    press_cnt_next = press_cnt_reg;
    if (!pwr_switch) begin
        press_cnt_next = 32'h0;
    end else if (!cnt_full) begin
        press_cnt_next = cnt_inc;
    end
end

// a forced press stays spent until the switch is let go, so its
// release cannot bring the system straight back on
always @* begin
    forced_next = forced_reg;
    if (!pwr_switch) begin
        forced_next = 1'b0;
    end else if (long_hit) begin
        forced_next = 1'b1;
    end
end

// remember on/off only while ac is present; the cycle that sees ac
// drop leaves the value from the last live cycle in place
always @* begin
    last_on_next = last_on_reg;
    if (ac_present) begin
        last_on_next = (state_reg == ST_S0);
    end
end

// ----------------------------------------
// registers
// ----------------------------------------
// delayed switch resets low, its idle level, so no false release follows reset
always @(posedge clk_sys) begin
    if (rst) begin
        state_reg     <= ST_G3;
        press_cnt_reg <= 32'h0;
        sw_dly_reg    <= 1'b0;
        forced_reg    <= 1'b0;
        last_on_reg   <= 1'b0;
    end else begin
        state_reg     <= state_next;
        press_cnt_reg <= press_cnt_next;
        sw_dly_reg    <= pwr_switch;
        forced_reg    <= forced_next;
        last_on_reg   <= last_on_next;
    end
end

// ----------------------------------------
// rail outputs
// ----------------------------------------
// driven from the next state so rails and status move on the same edge
always @(posedge clk_sys) begin
    if (rst) begin
        sys_state   <= ST_G3;
        cpu_pwr_en  <= 1'b0;
        mem_pwr_en  <= 1'b0;
        dev_pwr_en  <= 1'b0;
        wake_pwr_en <= 1'b0;
    end else begin
        sys_state   <= state_next;
        cpu_pwr_en  <= (state_next == ST_S0);
        dev_pwr_en  <= (state_next == ST_S0);
        mem_pwr_en  <= (state_next == ST_S0) |
                       (state_next == ST_S3);
        wake_pwr_en <= (state_next != ST_G3);
    end
end

// ----------------------------------------
// event pulses
// ----------------------------------------
// one cycle each; force-off only flags when the long press really moves
// the state, so a supply loss in the same cycle shows as g3 alone
always @(posedge clk_sys) begin
    if (rst) begin
        cold_boot     <= 1'b0;
        force_off_evt <= 1'b0;
    end else begin
        cold_boot     <= (state_reg == ST_S5) & (state_next == ST_S0);
        force_off_evt <= long_hit & can_force & (state_next == ST_S5);
    end
end

endmodule // pbsc_ctrl

// ==== rtl/pbsc_regs.vh ====
`ifndef PBSC_REGS_VH
`define PBSC_REGS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define PBSC_CLK_MHZ        250
`define PBSC_SHORT_SEC      4
`define PBSC_LONG_SEC       6
// cycles for the thresholds; long time is an exact product used as a least hold time
`define PBSC_SHORT_CYC      (`PBSC_SHORT_SEC * `PBSC_CLK_MHZ * 1000000)
`define PBSC_LONG_CYC       (`PBSC_LONG_SEC * `PBSC_CLK_MHZ * 1000000)
`define PBSC_CNT_W          32

// ----------------------------------------
// state codes (sleeping state numbering)
// ----------------------------------------
`define PBSC_ST_W           3
`define PBSC_ST_S0          3'h0
`define PBSC_ST_S3          3'h3
`define PBSC_ST_S4          3'h4
`define PBSC_ST_S5          3'h5
`define PBSC_ST_G3          3'h7

// sleep target select from the operating system
`define PBSC_SEL_S3         2'h0
`define PBSC_SEL_S4         2'h1
`define PBSC_SEL_S5         2'h2

// wake source count
`define PBSC_WAKE_N         4

`endif

// ==== tb/pbsc_ctrl_sva.sv ====
`timescale 1ns/1ps
// ------------------------------
// power state checker
// ------------------------------
module pbsc_ctrl_sva (
    // clock and reset
    input wire       clk_sys,
    input wire       rst,
    // controller inputs
    input wire       ac_present,
    input wire       pwr_switch,
    input wire       os_sleep_req,
    input wire       os_off_req,
    input wire       restore_last,
    input wire       pcie_wake_n,
    input wire [1:0] os_sleep_sel,
    input wire [2:0] wake_evt,
    // controller outputs
    input wire [2:0] sys_state,
    input wire       cpu_pwr_en,
    input wire       mem_pwr_en,
    input wire       dev_pwr_en,
    input wire       wake_pwr_en,
    input wire       cold_boot,
    input wire       force_off_evt
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // switch idle on live supply; a held switch may outrank the request
    wire idle = ac_present && !pwr_switch;
    wire slp  = sys_state == 3'h3 || sys_state == 3'h4 || sys_state == 3'h5;
    property p_cpu; cpu_pwr_en == (sys_state == 3'h0) && dev_pwr_en == cpu_pwr_en; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu or device rail wrong");
    property p_mem; mem_pwr_en == (sys_state == 3'h0 || sys_state == 3'h3); endproperty
    a_mem: assert property (p_mem) else $error("memory rail wrong");
    property p_wak; wake_pwr_en == (sys_state != 3'h7); endproperty
    a_wak: assert property (p_wak) else $error("wake rail wrong");
    property p_off; sys_state == 3'h0 && os_off_req && idle |=> sys_state == 3'h5; endproperty
    a_off: assert property (p_off) else $error("soft off request ignored");
    property p_slp; sys_state == 3'h0 && os_sleep_req && !os_off_req && idle && os_sleep_sel == 2'h0 |=> sys_state == 3'h3; endproperty
    a_slp: assert property (p_slp) else $error("sleep request ignored");
    property p_wake; slp && idle && (!pcie_wake_n || |wake_evt) |=> sys_state == 3'h0; endproperty
    a_wake: assert property (p_wake) else $error("wake not taken");
    property p_cold; sys_state == 3'h5 ##1 sys_state == 3'h0 |-> cold_boot; endproperty
    a_cold: assert property (p_cold) else $error("no cold boot pulse");
    property p_fo; force_off_evt |-> sys_state == 3'h5 && $past(pwr_switch); endproperty
    a_fo: assert property (p_fo) else $error("bad forced off");
    property p_g3; !ac_present |=> sys_state == 3'h7 && !cpu_pwr_en; endproperty
    a_g3: assert property (p_g3) else $error("supply loss not off");
    c_fo: cover property (force_off_evt);
    c_cold: cover property (cold_boot);
    c_s4: cover property (sys_state == 3'h4);
endmodule // pbsc_ctrl_sva

bind pbsc_ctrl pbsc_ctrl_sva u_sva (.clk_sys, .rst, .ac_present, .pwr_switch, .os_sleep_req, .os_off_req,
    .restore_last, .pcie_wake_n, .os_sleep_sel, .wake_evt, .sys_state, .cpu_pwr_en, .mem_pwr_en,
    .dev_pwr_en, .wake_pwr_en, .cold_boot, .force_off_evt);

// ==== tb/pbsc_os_model.sv ====
`timescale 1ns/1ps
// os requests and switch presses; cmd 1 sleep, 2 off, 3 press for len cycles
module pbsc_os_model (
    input wire        clk_sys,
    input wire [1:0]  cmd,
    input wire [7:0]  len,
    output logic      pwr_switch = 1'b0,
    output logic      os_sleep_req = 1'b0,
    output logic      os_off_req = 1'b0
);
    logic [7:0] cnt_reg = 8'h00;
    // requests are single cycle so the design never sees a stale one
    always @(posedge clk_sys) begin
        os_sleep_req <= (cmd == 2'h1);
        os_off_req   <= (cmd == 2'h2);
        cnt_reg      <= (cmd == 2'h3) ? len : (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
        pwr_switch   <= (cmd == 2'h3) || (cnt_reg > 8'h01);
    end
endmodule // pbsc_os_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0, rst = 1'b1, ac_present = 1'b1, restore_last = 1'b0, pcie_wake_n = 1'b1;
    logic [2:0] wake_evt = 3'h0;
    logic [1:0] os_sleep_sel = 2'h0, cmd = 2'h0;
    logic [7:0] len = 8'h00;
    wire pwr_switch, os_sleep_req, os_off_req, cpu_pwr_en, mem_pwr_en, dev_pwr_en, wake_pwr_en, cold_boot;
    wire force_off_evt;
    wire [2:0] sys_state;
    int mismatches = 0, compares = 0, cyc = 0, fo_cnt = 0, cold_cnt = 0;
    logic [1:0] sel;
    always #2 clk_sys = ~clk_sys;
    // short counts: 20 and 30 cycles stand in for four and six seconds
    pbsc_ctrl #(.SHORT_CYC(32'h14), .LONG_CYC(32'h1e)) dut (.clk_sys, .rst, .ac_present, .pwr_switch,
        .os_sleep_sel, .os_sleep_req, .os_off_req, .restore_last, .pcie_wake_n, .wake_evt, .sys_state,
        .cpu_pwr_en, .mem_pwr_en, .dev_pwr_en, .wake_pwr_en, .cold_boot, .force_off_evt);
    pbsc_os_model u_os (.clk_sys, .cmd, .len, .pwr_switch, .os_sleep_req, .os_off_req);
    task chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t value %h expected %h", $time, s, e);
        end
    endtask
    task wt(input int n); repeat (n) @(posedge clk_sys); endtask
    // one request, then enough cycles for release detection and the state edge
    task op(input logic [1:0] c, input logic [7:0] l);
        cmd <= c;
        len <= l;
        wt(1);
        cmd <= 2'h0;
        wt(int'(l) + 5);
    endtask
    function logic [2:0] exp_sel(input logic [1:0] s);
        return (s == 2'h0) ? 3'h3 : (s == 2'h1) ? 3'h4 : 3'h5;
    endfunction
    // rails as {cpu, memory, wake}; memory survives only S0 and S3
    function logic [2:0] exp_rail(input logic [2:0] s);
        return {s == 3'h0, s == 3'h0 || s == 3'h3, s != 3'h7};
    endfunction
    // pulses stand one cycle; each is counted at the edge after launch
    always @(posedge clk_sys) begin
        if (force_off_evt === 1'b1) fo_cnt++;
        if (cold_boot === 1'b1) cold_cnt++;
    end
    task test_done;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h56c1));
        wt(20);
        rst <= 1'b0;
        wt(4);
        chk(sys_state, 3'h5);
        op(2'h3, 8'h05);
        chk(sys_state, 3'h0);
        for (int i = 0; i < 4; i++) begin
            os_sleep_sel <= 2'(i);
            op(2'h1, 8'h00);
            chk(sys_state, exp_sel(2'(i)));
            chk({cpu_pwr_en, mem_pwr_en, wake_pwr_en}, exp_rail(exp_sel(2'(i))));
            if (i[0]) pcie_wake_n <= 1'b0;
            else wake_evt <= 3'(1 << ($urandom % 3));
            wt(2);
            pcie_wake_n <= 1'b1;
            wake_evt <= 3'h0;
            wt(2);
            chk(sys_state, 3'h0);
        end
        // S3 or S4 only, so a mid press is told apart from a forced off
        sel = 2'($urandom % 2);
        os_sleep_sel <= sel;
        op(2'h3, 8'(22 + $urandom % 6));
        chk(sys_state, exp_sel(sel));
        op(2'h3, 8'h28);
        chk(sys_state, 3'h5);
        op(2'h3, 8'h03);
        op(2'h3, 8'h28);
        chk(sys_state, 3'h5);
        op(2'h3, 8'h03);
        op(2'h2, 8'h00);
        chk(sys_state, 3'h5);
        ac_present <= 1'b0;
        wt(3);
        chk(sys_state, 3'h7);
        chk({cpu_pwr_en, mem_pwr_en, wake_pwr_en}, exp_rail(3'h7));
        ac_present <= 1'b1;
        wt(3);
        chk(sys_state, 3'h5);
        op(2'h3, 8'h03);
        restore_last <= 1'b1;
        ac_present <= 1'b0;
        wt(3);
        ac_present <= 1'b1;
        wt(3);
        chk(sys_state, 3'h0);
        // forced off from sleep and from working; six S5 to S0 exits
        chk(8'(fo_cnt), 8'h02);
        chk(8'(cold_cnt), 8'h06);
        test_done();
    end
endmodule // testbench
